// File: seerp_pkg.sv
// Shared constants for the two-wire EEPROM read and protect link
package seerp_pkg;
   localparam int SEERP_AW = 15;
   localparam int SEERP_DEPTH = 32768;
   localparam logic [4:0] SEERP_DEV_CODE = 5'h14;
   localparam int SEERP_PAGE_BITS = 6;
   localparam int SEERP_CLK_MHZ = 100;
   localparam int SEERP_WR_TIME_US = 10000;
   localparam int SEERP_WR_CYCLES = SEERP_WR_TIME_US * SEERP_CLK_MHZ;
   localparam int SEERP_SCL_HALF = 8;
   localparam logic SEERP_DIR_READ = 1'b1;
   localparam logic SEERP_DIR_WRITE = 1'b0;
endpackage

// File: seerp_if.sv
// Two-wire bus with wired-AND data and clock
`timescale 1ns/1ps
interface seerp_if;
   logic scl_out;
   logic scl_oe;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   wire scl = ~(scl_oe & ~scl_out);
   wire sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));
   modport dev (input scl, input sda, output sda_s_out, output sda_s_oe);
   modport mst (input scl, input sda, output scl_out, output scl_oe, output sda_m_out, output sda_m_oe);
endinterface

// File: seerp_dev.sv
// EEPROM slave end: protect, write and all reads
`timescale 1ns/1ps
module seerp_dev
   import seerp_pkg::*;
#(
   parameter int WR_CYCLES = SEERP_WR_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   seerp_if.dev bus,
   input wire logic i_select_pin_low,
   input wire logic i_select_pin_high,
   input wire logic i_wp,
   output logic o_busy
);
   typedef enum logic [6:0] {
      SEERP_S_IDLE = 7'h01,
      SEERP_S_DEVA = 7'h02,
      SEERP_S_ADRH = 7'h04,
      SEERP_S_ADRL = 7'h08,
      SEERP_S_WDAT = 7'h10,
      SEERP_S_RDAT = 7'h20,
      SEERP_S_WAIT = 7'h40
   } seerp_dst_t;
   logic [7:0] mem [SEERP_DEPTH];
   logic [2:0] scl_s, sda_s;
   logic [1:0] sel_m, sel_s;
   logic wp_m, wp_s;
   seerp_dst_t st, next_st;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh;
   logic [SEERP_AW-1:0] ptr, next_ptr;
   logic rd, next_rd, ack, next_ack, drv, next_drv, pend, next_pend, bad, next_bad;
   logic [31:0] busy_cnt, next_busy_cnt;
   logic we;
   logic [7:0] rdata;
   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire start_c = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
   wire stop_c = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
   wire busy = busy_cnt != 32'h0;
   assign rdata = mem[ptr];
   always_ff @(posedge i_mclk)
   begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      sel_m <= {i_select_pin_high, i_select_pin_low};
      sel_s <= sel_m;
      wp_m <= i_wp;
      wp_s <= wp_m;
      if (we)
      begin
         mem[ptr] <= sh;
      end
   end
   always_comb
   begin
      next_st = st;
      next_bitn = bitn;
      next_sh = sh;
      next_ptr = ptr;
      next_rd = rd;
      next_ack = ack;
      next_drv = drv;
      next_pend = pend;
      next_bad = bad;
      next_busy_cnt = busy ? busy_cnt - 32'h1 : busy_cnt;
      we = 1'b0;
      if (stop_c)
      begin
         next_st = SEERP_S_IDLE;
         next_drv = 1'b0;
         if (pend && !bad)
         begin
            next_busy_cnt = 32'(WR_CYCLES);
         end
         next_pend = 1'b0;
         next_bad = 1'b0;
      end
      else if (start_c)
      begin
         next_st = busy ? SEERP_S_IDLE : SEERP_S_DEVA;
         // Clock fall after start wraps this to bit 0
         next_bitn = 4'hF;
         next_drv = 1'b0;
         next_ack = 1'b0;
      end
      else if (scl_rise)
      begin
         if (bitn < 4'h8)
         begin
            next_sh = {sh[6:0], sda_s[1]};
         end
         else if (st == SEERP_S_RDAT)
         begin
            next_ack = ~sda_s[1];
         end
      end
      else if (scl_fall && st != SEERP_S_IDLE && st != SEERP_S_WAIT)
      begin
         next_bitn = bitn + 4'h1;
         next_drv = 1'b0;
         if (st == SEERP_S_RDAT && bitn < 4'h7)
         begin
            next_drv = ~sh[7];
         end
         if (bitn == 4'h7)
         begin
            case (st)
               SEERP_S_DEVA:
               begin
                  if (sh[7:3] == SEERP_DEV_CODE && sh[2:1] == sel_s)
                  begin
                     next_drv = 1'b1;
                     next_rd = sh[0];
                  end
                  else
                  begin
                     next_st = SEERP_S_IDLE;
                  end
               end
               SEERP_S_ADRH, SEERP_S_ADRL:
               begin
                  next_drv = 1'b1;
               end
               SEERP_S_WDAT:
               begin
                  if (wp_s)
                  begin
                     next_bad = 1'b1;
                     next_st = SEERP_S_WAIT;
                  end
                  else
                  begin
                     next_drv = 1'b1;
                     we = 1'b1;
                     next_pend = 1'b1;
                     next_ptr = {ptr[SEERP_AW-1:SEERP_PAGE_BITS], ptr[SEERP_PAGE_BITS-1:0] + 6'h1};
                  end
               end
               default:
               begin
               end
            endcase
         end
         else if (bitn == 4'h8)
         begin
            next_bitn = 4'h0;
            case (st)
               SEERP_S_DEVA:
               begin
                  if (rd == SEERP_DIR_READ)
                  begin
                     next_st = SEERP_S_RDAT;
                     next_sh = rdata;
                     next_drv = ~rdata[7];
                     next_ptr = ptr + 15'h1;
                  end
                  else
                  begin
                     next_st = SEERP_S_ADRH;
                  end
               end
               SEERP_S_ADRH:
               begin
                  next_ptr = {sh[SEERP_AW-9:0], ptr[7:0]};
                  next_st = SEERP_S_ADRL;
               end
               SEERP_S_ADRL:
               begin
                  next_ptr = {ptr[SEERP_AW-1:8], sh};
                  next_st = SEERP_S_WDAT;
               end
               SEERP_S_RDAT:
               begin
                  if (ack)
                  begin
                     next_sh = rdata;
                     next_drv = ~rdata[7];
                     next_ptr = ptr + 15'h1;
                  end
                  else
                  begin
                     next_st = SEERP_S_WAIT;
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         st <= SEERP_S_IDLE;
         bitn <= 4'h0;
         sh <= 8'h00;
         ptr <= '0;
         rd <= 1'b0;
         ack <= 1'b0;
         drv <= 1'b0;
         pend <= 1'b0;
         bad <= 1'b0;
         busy_cnt <= 32'h0;
         o_busy <= 1'b0;
      end
      else
      begin
         st <= next_st;
         bitn <= next_bitn;
         sh <= next_sh;
         ptr <= next_ptr;
         rd <= next_rd;
         ack <= next_ack;
         drv <= next_drv;
         pend <= next_pend;
         bad <= next_bad;
         busy_cnt <= next_busy_cnt;
         o_busy <= next_busy_cnt != 32'h0;
      end
   end
   assign bus.sda_s_out = 1'b0;
   assign bus.sda_s_oe = drv;
endmodule

// File: seerp_mst.sv
// Bus master end: random, current and sequential reads, writes
`timescale 1ns/1ps
module seerp_mst
   import seerp_pkg::*;
#(
   parameter int HALF = SEERP_SCL_HALF
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   seerp_if.mst bus,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic i_req_setaddr,
   input wire logic [14:0] i_req_addr,
   input wire logic [7:0] i_req_wdata,
   input wire logic [7:0] i_req_count,
   input wire logic [1:0] i_req_sel,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [7:0] o_rd_data,
   output logic o_done,
   output logic o_nack
);
   typedef enum logic [5:0] {
      SEERP_M_IDLE = 6'h01,
      SEERP_M_START = 6'h02,
      SEERP_M_BYTE = 6'h04,
      SEERP_M_RDB = 6'h08,
      SEERP_M_STOP = 6'h10,
      SEERP_M_FIN = 6'h20
   } seerp_mst_t;
   logic [1:0] sda_s;
   seerp_mst_t st, next_st;
   logic [7:0] div, next_div;
   logic [1:0] ph, next_ph;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh;
   logic [2:0] step, next_step;
   logic [7:0] cnt, next_cnt;
   logic wr, next_wr, sa, next_sa, nk, next_nk, sclo, next_sclo, sdao, next_sdao;
   logic [14:0] adr, next_adr;
   logic [7:0] wd, next_wd;
   logic [1:0] sel, next_sel;
   logic [7:0] bq [2];
   logic [1:0] bn, next_bn;
   logic bw, next_bw, br, next_br;
   wire tick = div == 8'(HALF - 1);
   wire full = bn == 2'h2;
   wire [7:0] devb = {SEERP_DEV_CODE, sel, SEERP_DIR_WRITE};
   always_ff @(posedge i_mclk)
   begin
      sda_s <= {sda_s[0], bus.sda};
      if (bn != 2'h2 && br)
      begin
         bq[bw] <= sh;
      end
   end
   always_comb
   begin
      next_st = st;
      next_div = tick ? 8'h00 : div + 8'h1;
      next_ph = ph;
      next_bitn = bitn;
      next_sh = sh;
      next_step = step;
      next_cnt = cnt;
      next_wr = wr;
      next_sa = sa;
      next_nk = nk;
      next_sclo = sclo;
      next_sdao = sdao;
      next_adr = adr;
      next_wd = wd;
      next_sel = sel;
      next_bn = bn;
      next_bw = bw;
      next_br = 1'b0;
      if (o_rd_valid && i_rd_ready)
      begin
         next_bn = next_bn - 2'h1;
      end
      if (br)
      begin
         next_bn = next_bn + 2'h1;
         next_bw = ~bw;
      end
      if (st == SEERP_M_IDLE)
      begin
         if (i_req_valid)
         begin
            next_wr = i_req_write;
            next_sa = i_req_setaddr | i_req_write;
            next_adr = i_req_addr;
            next_wd = i_req_wdata;
            next_cnt = i_req_count;
            next_sel = i_req_sel;
            next_nk = 1'b0;
            next_step = 3'h0;
            next_ph = 2'h0;
            next_st = SEERP_M_START;
         end
      end
      else if (st == SEERP_M_FIN)
      begin
         next_st = SEERP_M_IDLE;
      end
      else if (tick && !(st == SEERP_M_RDB && full && bitn == 4'h8 && ph == 2'h0))
      begin
         next_ph = ph + 2'h1;
         case (st)
            SEERP_M_START:
            begin
               if (ph == 2'h0)
               begin
                  next_sdao = 1'b1;
               end
               else if (ph == 2'h1)
               begin
                  next_sclo = 1'b1;
               end
               else if (ph == 2'h2)
               begin
                  next_sdao = 1'b0;
               end
               else
               begin
                  next_sclo = 1'b0;
                  next_bitn = 4'h0;
                  next_st = SEERP_M_BYTE;
                  next_sh = (step == 3'h0 && !sa) || step == 3'h3 ? devb | 8'h01 : devb;
                  next_step = step == 3'h0 && !sa ? 3'h3 : step;
               end
            end
            SEERP_M_BYTE, SEERP_M_RDB:
            begin
               if (ph == 2'h0)
               begin
                  next_sdao = st == SEERP_M_RDB ? (bitn == 4'h8 ? cnt == 8'h1 : 1'b1)
                     : (bitn == 4'h8 ? 1'b1 : sh[7]);
               end
               else if (ph == 2'h1)
               begin
                  next_sclo = 1'b1;
               end
               else if (ph == 2'h2)
               begin
                  if (bitn < 4'h8)
                  begin
                     next_sh = {sh[6:0], sda_s[1]};
                  end
                  else if (st == SEERP_M_BYTE && sda_s[1])
                  begin
                     next_nk = 1'b1;
                  end
               end
               else
               begin
                  next_sclo = 1'b0;
                  next_bitn = bitn + 4'h1;
                  if (bitn == 4'h8)
                  begin
                     next_bitn = 4'h0;
                     if (st == SEERP_M_RDB)
                     begin
                        next_br = 1'b1;
                        next_cnt = cnt - 8'h1;
                        next_st = cnt == 8'h1 ? SEERP_M_STOP : SEERP_M_RDB;
                     end
                     else if (nk)
                     begin
                        next_st = SEERP_M_STOP;
                     end
                     else
                     begin
                        next_step = step + 3'h1;
                        case (step)
                           3'h0: next_sh = {1'b0, adr[14:8]};
                           3'h1: next_sh = adr[7:0];
                           3'h2:
                           begin
                              if (wr)
                              begin
                                 next_sh = wd;
                                 next_step = 3'h4;
                              end
                              else
                              begin
                                 next_st = SEERP_M_START;
                              end
                           end
                           3'h3:
                           begin
                              next_st = cnt == 8'h0 ? SEERP_M_STOP : SEERP_M_RDB;
                           end
                           default: next_st = SEERP_M_STOP;
                        endcase
                     end
                  end
               end
            end
            SEERP_M_STOP:
            begin
               if (ph == 2'h0)
               begin
                  next_sdao = 1'b0;
               end
               else if (ph == 2'h1)
               begin
                  next_sclo = 1'b1;
               end
               else if (ph == 2'h2)
               begin
                  next_sdao = 1'b1;
               end
               else
               begin
                  next_st = SEERP_M_FIN;
               end
            end
            default:
            begin
            end
         endcase
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         st <= SEERP_M_IDLE;
         div <= 8'h00;
         ph <= 2'h0;
         bitn <= 4'h0;
         sh <= 8'h00;
         step <= 3'h0;
         cnt <= 8'h00;
         wr <= 1'b0;
         sa <= 1'b0;
         nk <= 1'b0;
         sclo <= 1'b1;
         sdao <= 1'b1;
         adr <= 15'h0000;
         wd <= 8'h00;
         sel <= 2'h0;
         bn <= 2'h0;
         bw <= 1'b0;
         br <= 1'b0;
         o_req_ready <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= 8'h00;
         o_done <= 1'b0;
         o_nack <= 1'b0;
      end
      else
      begin
         st <= next_st;
         div <= next_div;
         ph <= next_ph;
         bitn <= next_bitn;
         sh <= next_sh;
         step <= next_step;
         cnt <= next_cnt;
         wr <= next_wr;
         sa <= next_sa;
         nk <= next_nk;
         sclo <= next_sclo;
         sdao <= next_sdao;
         adr <= next_adr;
         wd <= next_wd;
         sel <= next_sel;
         bn <= next_bn;
         bw <= next_bw;
         br <= next_br;
         o_req_ready <= next_st == SEERP_M_IDLE && !(st == SEERP_M_IDLE && i_req_valid);
         o_rd_valid <= next_bn != 2'h0;
         o_rd_data <= next_bn == 2'h0 ? 8'h00 : (bn == 2'h0 || (bn == 2'h1 && o_rd_valid && i_rd_ready)
            ? sh : bq[next_bw ^ next_bn[0]]);
         o_done <= st == SEERP_M_FIN;
         o_nack <= st == SEERP_M_FIN && nk;
      end
   end
   assign bus.scl_out = 1'b0;
   assign bus.scl_oe = ~sclo;
   assign bus.sda_m_out = 1'b0;
   assign bus.sda_m_oe = ~sdao;
endmodule

// File: seerp_assertions.sv
// Wire-level checks of the two-wire EEPROM link
`timescale 1ns/1ps
module seerp_assertions
   import seerp_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe,
   input wire logic i_select_pin_low,
   input wire logic i_select_pin_high,
   input wire logic i_wp,
   input wire logic o_busy
);
   logic scl_q, sda_q, sel, wrote, bz, next_sel, next_wrote, next_bz;
   logic [3:0] bitn, next_bitn;
   logic [2:0] bytn, next_bytn;
   logic [7:0] sh, adr, next_sh, next_adr;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stop = scl & scl_q & ~sda_q & sda;
   wire slot9 = scl & ~scl_q & (bitn == 4'h8);
   wire match = (adr[7:3] == SEERP_DEV_CODE) && (adr[2:1] == {i_select_pin_high, i_select_pin_low});

   // Bit and byte tracking since START
   always_comb
   begin
      next_bitn = bitn;
      next_bytn = bytn;
      next_sh = sh;
      next_adr = adr;
      next_sel = sel;
      next_wrote = wrote;
      next_bz = bz | o_busy;
      if (start)
      begin
         next_bitn = 4'h0;
         next_bytn = 3'h0;
         next_sel = 1'h0;
         next_wrote = 1'h0;
         next_bz = o_busy;
      end
      else if (scl & ~scl_q)
      begin
         if (bitn == 4'h8)
         begin
            next_bitn = 4'h0;
            if (bytn != 3'h7)
               next_bytn = bytn + 3'h1;
            if (bytn == 3'h0 && sda_s_oe)
               next_sel = 1'h1;
            if (bytn >= 3'h3 && !adr[0] && sda_s_oe)
               next_wrote = 1'h1;
         end
         else
         begin
            next_bitn = bitn + 4'h1;
            next_sh = {sh[6:0], sda};
            if (bitn == 4'h7 && bytn == 3'h0)
               next_adr = {sh[6:0], sda};
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      scl_q <= scl;
      sda_q <= sda;
      sh <= next_sh;
      adr <= next_adr;
      if (i_srst)
      begin
         bitn <= 4'h0;
         bytn <= 3'h0;
         sel <= 1'h0;
         wrote <= 1'h0;
         bz <= 1'h0;
      end
      else
      begin
         bitn <= next_bitn;
         bytn <= next_bytn;
         sel <= next_sel;
         wrote <= next_wrote;
         bz <= next_bz;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   sequence s_addr_slot;
      slot9 && bytn == 3'h0;
   endsequence
   sequence s_rd_nack;
      slot9 && bytn != 3'h0 && adr[0] && sel && sda;
   endsequence
   sequence s_wr_stop;
      stop && wrote;
   endsequence

   a_addr_match: assert property (s_addr_slot ##0 sda_s_oe |-> match)
      else $error("device acked a foreign address");
   a_addr_acked: assert property (s_addr_slot ##0 (match && !bz) |-> sda_s_oe)
      else $error("own address not acked");
   a_busy_no_ack: assert property (s_addr_slot ##0 bz |-> !sda_s_oe)
      else $error("address acked while programming");
   a_word_addr_ack: assert property (slot9 && (bytn == 3'h1 || bytn == 3'h2) && !adr[0] && sel |-> sda_s_oe)
      else $error("byte address not acked");
   a_wp_data_nack: assert property (slot9 && bytn == 3'h3 && !adr[0] && sel && i_wp |-> !sda_s_oe)
      else $error("protected data byte acked");
   a_wp_no_prog: assert property ($rose(o_busy) |-> !i_wp)
      else $error("programming started while protected");
   a_prog_after_stop: assert property (s_wr_stop |-> ##[1:8] o_busy)
      else $error("no programming after write stop");
   a_read_ack_free: assert property (slot9 && bytn != 3'h0 && adr[0] && sel |-> !sda_s_oe)
      else $error("device drove the master ack slot");
   a_nack_silence: assert property (s_rd_nack |=> (!sda_s_oe) [*8])
      else $error("device kept sending after nack");
   a_hold_scl_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
      else $error("device data changed while clock high");
endmodule

// File: tb.sv
// Self-checking bench with both link ends joined
`timescale 1ns/1ps
module tb;
   import seerp_pkg::*;
   localparam int WRC = 400;
   logic i_mclk, i_srst, wp, req_valid, req_write, req_setaddr, rd_ready, busy, req_ready, rd_valid, done, nack;
   logic [14:0] req_addr;
   logic [7:0] req_wdata, req_count, rd_data;
   logic [1:0] req_sel;
   logic [7:0] rdq[$];
   int fail_count, checked, cyc;

   seerp_if bus_if();
   seerp_dev #(.WR_CYCLES(WRC)) seerp_dev_i(.i_mclk(i_mclk), .i_srst(i_srst), .bus(bus_if),
      .i_select_pin_low(1'h0), .i_select_pin_high(1'h1), .i_wp(wp), .o_busy(busy));
   seerp_mst #(.HALF(4)) seerp_mst_i(.i_mclk(i_mclk), .i_srst(i_srst), .bus(bus_if), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req_write(req_write), .i_req_setaddr(req_setaddr), .i_req_addr(req_addr),
      .i_req_wdata(req_wdata), .i_req_count(req_count), .i_req_sel(req_sel), .o_rd_valid(rd_valid),
      .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_done(done), .o_nack(nack));
   seerp_assertions seerp_assertions_i(.i_mclk(i_mclk), .i_srst(i_srst), .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_s_oe(bus_if.sda_s_oe), .i_select_pin_low(1'h0), .i_select_pin_high(1'h1), .i_wp(wp), .o_busy(busy));

   initial
   begin
      i_mclk = 1'h0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge i_mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         fail_count++;
         end_sim;
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One request on the user side, bytes collected, receiver stalled for a while
   task automatic xfer(input logic wr, input logic sa, input logic [14:0] a, input logic [7:0] wd,
      input logic [7:0] n, input logic [1:0] sl, input int stall, output logic nk);
      int t;
      t = 0;
      nk = 1'h1;
      rdq.delete();
      do
      begin
         @(posedge i_mclk);
         t++;
      end
      while (req_ready !== 1'h1 && t < 2000);
      req_valid <= 1'h1;
      req_write <= wr;
      req_setaddr <= sa;
      req_addr <= a;
      req_wdata <= wd;
      req_count <= n;
      req_sel <= sl;
      @(posedge i_mclk);
      req_valid <= 1'h0;
      for (t = 0; t < 20000; t++)
      begin
         @(posedge i_mclk);
         if (rd_valid === 1'h1 && rd_ready === 1'h1)
            rdq.push_back(rd_data);
         if (done === 1'h1)
         begin
            nk = nack;
            break;
         end
         rd_ready <= (t >= stall);
      end
      rd_ready <= 1'h1;
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic nk;
      xfer(1'h1, 1'h0, a, d, 8'h00, 2'h2, 0, nk);
      chk1(nk, 1'h0);
      chk1(busy, 1'h1);
      repeat (WRC + 20) @(posedge i_mclk);
   endtask

   task automatic rd(input logic sa, input logic [14:0] a, input logic [7:0] n, input int stall);
      logic nk;
      xfer(1'h0, sa, a, 8'h00, n, 2'h2, stall, nk);
      chk1(nk, 1'h0);
      chk8(8'(rdq.size()), n);
   endtask

   task automatic t_current;
      wr(15'h0010, 8'hA5);
      wr(15'h0011, 8'h5A);
      rd(1'h1, 15'h0010, 8'h01, 0);
      chk8(rdq[0], 8'hA5);
      rd(1'h0, 15'h0000, 8'h01, 0);
      chk8(rdq[0], 8'h5A);
      $display("test current done");
   endtask

   task automatic t_seq_wrap;
      logic [7:0] ex[3];
      ex = '{8'h3C, 8'hC3, 8'h96};
      wr(15'h7FFE, 8'h3C);
      wr(15'h7FFF, 8'hC3);
      wr(15'h0000, 8'h96);
      rd(1'h1, 15'h7FFE, 8'h03, 900);
      foreach (ex[i]) chk8(rdq[i], ex[i]);
      rd(1'h1, 15'h7FFF, 8'h01, 0);
      chk8(rdq[0], 8'hC3);
      rd(1'h0, 15'h0000, 8'h01, 0);
      chk8(rdq[0], 8'h96);
      wr(15'h003F, 8'h77);
      rd(1'h0, 15'h0000, 8'h01, 0);
      chk8(rdq[0], 8'h96);
      $display("test seq_wrap done");
   endtask

   task automatic t_protect;
      logic nk;
      wp <= 1'h1;
      xfer(1'h1, 1'h0, 15'h0010, 8'hFF, 8'h00, 2'h2, 0, nk);
      chk1(nk, 1'h1);
      repeat (20) @(posedge i_mclk);
      chk1(busy, 1'h0);
      rd(1'h1, 15'h0010, 8'h01, 0);
      chk8(rdq[0], 8'hA5);
      wp <= 1'h0;
      $display("test protect done");
   endtask

   task automatic t_busy;
      logic nk;
      xfer(1'h1, 1'h0, 15'h0020, 8'h11, 8'h00, 2'h2, 0, nk);
      xfer(1'h0, 1'h1, 15'h0020, 8'h00, 8'h01, 2'h2, 0, nk);
      chk1(nk, 1'h1);
      repeat (WRC + 20) @(posedge i_mclk);
      rd(1'h1, 15'h0020, 8'h01, 0);
      chk8(rdq[0], 8'h11);
      $display("test busy done");
   endtask

   task automatic t_select;
      logic nk;
      for (int s = 0; s < 4; s++)
      begin
         xfer(1'h0, 1'h1, 15'h0010, 8'h00, 8'h01, 2'(s), 0, nk);
         chk1(nk, 1'(s != 2));
      end
      $display("test select done");
   endtask

   initial
   begin
      i_srst = 1'h1;
      wp = 1'h0;
      req_valid = 1'h0;
      req_write = 1'h0;
      req_setaddr = 1'h0;
      req_addr = 15'h0000;
      req_wdata = 8'h00;
      req_count = 8'h00;
      req_sel = 2'h0;
      rd_ready = 1'h1;
      fail_count = 0;
      checked = 0;
      cyc = 0;
      repeat (8) @(posedge i_mclk);
      i_srst <= 1'h0;
      repeat (2) @(posedge i_mclk);
      t_current;
      t_seq_wrap;
      t_protect;
      t_busy;
      t_select;
      end_sim;
   end
endmodule
